/* File: rtl/sec_pkg.sv */
package sec_pkg;
   // ==========================================================
   // Address map
   // ==========================================================
   localparam int          WORD_W       = 16;             // Width of every word
   localparam int          ADDR_W       = 6;              // Instruction address field
   localparam int          NUM_WORDS    = 62;             // Nonvolatile words 0..61
   localparam logic [5:0]  ADDR_BOOT    = 6'h3d;          // Word copied at power-up
   localparam logic [5:0]  ADDR_SETUP   = 6'h3e;          // switch_setup register
   localparam logic [5:0]  ADDR_SAMPLE  = 6'h3f;          // terminal_level_sample register

   // ==========================================================
   // Instruction encodings
   // ==========================================================
   localparam logic [1:0]  OP_EXT       = 2'h0;           // Extension, address bits select
   localparam logic [1:0]  OP_WRITE     = 2'h1;           // Write one word
   localparam logic [1:0]  OP_READ      = 2'h2;           // Read, sequential
   localparam logic [1:0]  EXT_LOCK     = 2'h0;           // lock_writes_cmd
   localparam logic [1:0]  EXT_FILL     = 2'h1;           // fill_all_cmd
   localparam logic [1:0]  EXT_UNLOCK   = 2'h3;           // Unlock writes
   localparam logic [2:0]  INSTR_LAST   = 3'h7;           // Last of 8 bits after lead bit
   localparam logic [3:0]  DATA_LAST    = 4'hf;           // Last of 16 payload bits

   // ==========================================================
   // Reset values and switch field codes
   // ==========================================================
   localparam logic [15:0] SETUP_RST    = 16'hcccc;       // All blocks open analog
   localparam logic [1:0]  FLD_ANALOG   = 2'h3;           // msb,b2 of analog modes
   localparam logic [1:0]  FLD_LEVEL    = 2'h0;           // msb,b2 of modes 0..3
   localparam logic [1:0]  FLD_A_SIDE   = 2'h1;           // Modes 4..7
   localparam logic [1:0]  FLD_B_SIDE   = 2'h2;           // Modes 8..11
   localparam logic [3:0]  SAMPLE_LOW   = 4'h8;           // First used sample bit
   localparam logic [7:0]  SAMPLE_ZERO  = 8'h00;          // Bits 7..0 of the sample

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int          CLK_HZ       = 40_000_000;     // Core clock rate
   localparam int          PROG_TIME_US = 10_000;         // Self-timed programming time
   localparam int          STAT_TIME_US = 1_000;          // Status observation window
   localparam int          PROG_CYC     = PROG_TIME_US * (CLK_HZ / 1_000_000);
   localparam int          STAT_CYC     = STAT_TIME_US * (CLK_HZ / 1_000_000);
   localparam logic [2:0]  SETTLE_CYC   = 3'h4;           // Wait after select falls

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [5:0] {
      SK_IDLE  = 6'h01,                                   // Mandatory clock before lead bit
      SK_HUNT  = 6'h02,                                   // Waiting for lead_one_bit
      SK_INSTR = 6'h04,                                   // Opcode and address bits
      SK_DATA  = 6'h08,                                   // payload_bits
      SK_READ  = 6'h10,                                   // Streaming read data
      SK_END   = 6'h20                                    // Ignore until deselect
   } sec_sk_state_t;

   typedef struct packed {
      logic        fill;                                  // Fill every word
      logic [5:0]  addr;                                  // Target address
      logic [15:0] data;                                  // Word to store
   } sec_wreq_t;
endpackage

/* File: rtl/sec_switch_eeprom.sv */
// Behaviour
// - 62 by 16 array, word 61 ordinary
// - Power-up copies word 61 to config
// - Address 62 config, written directly, unlimited
// - Address 63 read-only, write does nothing
// - Four 4-bit fields, one per block
// - Modes 0-3 drive b1 and lsb
// - Modes 4,7,8,11 drive constant, other tristate
// - Modes 5,9 follow, modes 6,10 invert
// - Modes 12,13 analog switch open, 14,15 closed
// - Terminals ignore select entirely
// - Readback captured at last address bit of a read of 63
// - Readback bits 7..0 read zero
// - Closed analog switch reads zero levels
// - Lead one, 2-bit opcode, 6-bit address
// - Locked at power-up, unlock/lock commands
// - Fill writes words 0..61, not config
// - Falling select starts programming cycle
// - Abort only before the last payload bit, or the last address bit if no payload
// - Read gives zero dummy, then 16 bits
// - Sequential read increments, wraps, no dummy
// - Deselect aborts, programming still completes
// - Status on output within window
// - Output high impedance unless data, status
module sec_switch_eeprom #(
   parameter int PROG_CYCLES = sec_pkg::PROG_CYC,        // Programming time in clk
   parameter int STAT_CYCLES = sec_pkg::STAT_CYC,        // Status window in clk
   parameter int BLOCKS      = 4                         // Switch blocks
) (
   // Core clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Serial link
   input  wire logic              serial_clock_in,
   input  wire logic              select_in,
   input  wire logic              serial_in,
   output logic                   serial_out,
   output logic                   serial_out_oe,
   // Switch terminals
   input  wire logic [BLOCKS-1:0] first_terminal_set_in,
   output logic      [BLOCKS-1:0] first_terminal_set_out,
   output logic      [BLOCKS-1:0] first_terminal_set_oe,
   input  wire logic [BLOCKS-1:0] second_terminal_set_in,
   output logic      [BLOCKS-1:0] second_terminal_set_out,
   output logic      [BLOCKS-1:0] second_terminal_set_oe,
   output logic      [BLOCKS-1:0] analog_closed
);
   // ==========================================================
   // Declarations
   // ==========================================================
   localparam int PW = $clog2(PROG_CYCLES + 1);           // Program counter width
   localparam int SW = $clog2(STAT_CYCLES + 1);           // Window counter width

   logic [15:0]           mem [sec_pkg::NUM_WORDS];      // Nonvolatile array
   logic [15:0]           switch_config_reg;             // Volatile setup word
   logic                  boot_ff;                       // Power-up copy pending
   logic [15:0]           sample_word_ff;                // Live terminal levels
   // Serial side
   logic                  ser_arst;                      // Reset or deselected
   sec_pkg::sec_sk_state_t sk_state_ff;
   logic [3:0]            cnt_ff;                        // Bit counter
   logic [6:0]            instr_sh_ff;                   // Instruction shifter
   logic [7:0]            instr_word;                    // Full 8 bits on last edge
   logic                  instr_last;                    // Last address bit edge
   logic [5:0]            addr_ff;                       // Current word address
   logic                  fill_ff;                       // Fill pending data
   logic [15:0]           sh_ff;                         // Data shifter
   logic                  do_bit_ff;                     // Serial data bit
   logic                  do_oe_ff;                      // Serial data enable
   logic                  lock_ff;                       // Writes locked
   logic [15:0]           switch_readback_reg;           // Captured levels
   sec_pkg::sec_wreq_t    wreq_ff;                       // Completed write
   logic                  wtgl_ff;                       // Toggles per write
   // Core side
   logic                  cs_m_ff, cs_s_ff, cs_d_ff;     // Select sync
   logic                  tg_m_ff, tg_s_ff, seen_ff;     // Toggle sync
   logic [BLOCKS-1:0]     fa_m_ff, fa_s_ff;              // First terminal sync
   logic [BLOCKS-1:0]     fb_m_ff, fb_s_ff;              // Second terminal sync
   logic [2:0]            settle_ff;                     // Wait after deselect
   logic                  act;                           // Take write request
   logic                  busy_ff;                       // Programming cycle
   logic [PW-1:0]         prog_ff;                       // Cycles left
   logic [SW-1:0]         win_ff;                        // Status window left
   logic                  prog_end;                      // Commit to array
   sec_pkg::sec_wreq_t    pend_ff;                       // Request in programming
   logic                  stat_on_ff;                    // Status shown
   logic                  stat_val_ff;                   // Ready level

   // Word fetch for reads: array, setup or sample
   function automatic logic [15:0] fetch(input logic [5:0] a, input logic [15:0] smp);
      logic [15:0] w;
      w = '0;
      if (a == sec_pkg::ADDR_SETUP)
         w = switch_config_reg;
      else if (a == sec_pkg::ADDR_SAMPLE)
         w = smp;
      else
         w = mem[a];
      return w;
   endfunction

   // ==========================================================
   // Serial side, clocked by serial_clock_in
   // ==========================================================
   assign ser_arst   = rst | ~select_in;
   assign instr_word = {instr_sh_ff, serial_in};
   assign instr_last = (sk_state_ff == sec_pkg::SK_INSTR) && (cnt_ff[2:0] == sec_pkg::INSTR_LAST);

   // Frame sequencer, cleared while deselected
   always_ff @(posedge serial_clock_in or posedge ser_arst) begin
      if (ser_arst) begin
         sk_state_ff <= sec_pkg::SK_IDLE;
         cnt_ff      <= '0;
         instr_sh_ff <= '0;
         addr_ff     <= '0;
         fill_ff     <= 1'b0;
         sh_ff       <= '0;
         do_bit_ff   <= 1'b0;
         do_oe_ff    <= 1'b0;
      end else begin
         case (sk_state_ff)
            // Swallow the clock that follows select
            sec_pkg::SK_IDLE: begin
               sk_state_ff <= sec_pkg::SK_HUNT;
            end
            // Wait for the leading one
            sec_pkg::SK_HUNT: begin
               if (serial_in) begin
                  sk_state_ff <= sec_pkg::SK_INSTR;
                  cnt_ff      <= '0;
               end
            end
            // Opcode then address, msb first
            sec_pkg::SK_INSTR: begin
               instr_sh_ff <= instr_word[6:0];
               cnt_ff      <= cnt_ff + 4'h1;
               if (instr_last) begin
                  addr_ff <= instr_word[5:0];
                  cnt_ff  <= '0;
                  fill_ff <= 1'b0;
                  case (instr_word[7:6])
                     // Read starts with the dummy zero
                     sec_pkg::OP_READ: begin
                        sk_state_ff <= sec_pkg::SK_READ;
                        do_bit_ff   <= 1'b0;
                        do_oe_ff    <= 1'b1;
                        sh_ff       <= fetch(instr_word[5:0], sample_word_ff);
                     end
                     sec_pkg::OP_WRITE: begin
                        sk_state_ff <= sec_pkg::SK_DATA;
                     end
                     sec_pkg::OP_EXT: begin
                        if (instr_word[5:4] == sec_pkg::EXT_FILL) begin
                           sk_state_ff <= sec_pkg::SK_DATA;
                           fill_ff     <= 1'b1;
                        end else begin
                           sk_state_ff <= sec_pkg::SK_END;
                        end
                     end
                     default: begin
                        sk_state_ff <= sec_pkg::SK_END;
                     end
                  endcase
               end
            end
            // Payload shift, msb first
            sec_pkg::SK_DATA: begin
               sh_ff  <= {sh_ff[14:0], serial_in};
               cnt_ff <= cnt_ff + 4'h1;
               if (cnt_ff == sec_pkg::DATA_LAST) begin
                  sk_state_ff <= sec_pkg::SK_END;
               end
            end
            // Stream words back to back
            sec_pkg::SK_READ: begin
               do_bit_ff <= sh_ff[15];
               cnt_ff    <= cnt_ff + 4'h1;
               if (cnt_ff == sec_pkg::DATA_LAST) begin
                  addr_ff <= addr_ff + 6'h01;
                  sh_ff   <= fetch(addr_ff + 6'h01, switch_readback_reg);
               end else begin
                  sh_ff <= {sh_ff[14:0], 1'b0};
               end
            end
            // Extra clocks do nothing
            sec_pkg::SK_END: begin
               sk_state_ff <= sec_pkg::SK_END;
            end
            default: begin
               sk_state_ff <= sec_pkg::SK_END;
            end
         endcase
      end
   end

   // Write lock, survives deselect
   always_ff @(posedge serial_clock_in or posedge rst) begin
      if (rst) begin
         lock_ff <= 1'b1;
      end else if (select_in && instr_last && instr_word[7:6] == sec_pkg::OP_EXT) begin
         if (instr_word[5:4] == sec_pkg::EXT_LOCK)
            lock_ff <= 1'b1;
         else if (instr_word[5:4] == sec_pkg::EXT_UNLOCK)
            lock_ff <= 1'b0;
      end
   end

   // Readback capture only on a read of the sample address
   always_ff @(posedge serial_clock_in or posedge rst) begin
      if (rst) begin
         switch_readback_reg <= '0;
      end else if (select_in && instr_last && instr_word[7:6] == sec_pkg::OP_READ
                   && instr_word[5:0] == sec_pkg::ADDR_SAMPLE) begin
         switch_readback_reg <= sample_word_ff;
      end
   end

   // Completed write handed to the core side by toggle
   always_ff @(posedge serial_clock_in or posedge rst) begin
      if (rst) begin
         wreq_ff <= '0;
         wtgl_ff <= 1'b0;
      end else if (select_in && sk_state_ff == sec_pkg::SK_DATA
                   && cnt_ff == sec_pkg::DATA_LAST && !lock_ff
                   && (fill_ff || addr_ff != sec_pkg::ADDR_SAMPLE)) begin
         wreq_ff <= '{fill: fill_ff, addr: addr_ff, data: {sh_ff[14:0], serial_in}};
         wtgl_ff <= ~wtgl_ff;
      end
   end

   // ==========================================================
   // Core side synchronisers
   // ==========================================================
   // Select three flops, toggle and terminal levels two flops each
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_m_ff <= 1'b0;
         cs_s_ff <= 1'b0;
         cs_d_ff <= 1'b0;
         tg_m_ff <= 1'b0;
         tg_s_ff <= 1'b0;
         fa_m_ff <= '0;
         fa_s_ff <= '0;
         fb_m_ff <= '0;
         fb_s_ff <= '0;
      end else begin
         cs_m_ff <= select_in;
         cs_s_ff <= cs_m_ff;
         cs_d_ff <= cs_s_ff;
         tg_m_ff <= wtgl_ff;
         tg_s_ff <= tg_m_ff;
         fa_m_ff <= first_terminal_set_in;
         fa_s_ff <= fa_m_ff;
         fb_m_ff <= second_terminal_set_in;
         fb_s_ff <= fb_m_ff;
      end
   end

   // ==========================================================
   // Write acceptance and programming timer
   // ==========================================================
   assign act      = (settle_ff == 3'h1) && (tg_s_ff != seen_ff);
   assign prog_end = busy_ff && (prog_ff == PW'(1));

   // Settle after falling select, then take any new request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_ff <= '0;
         seen_ff   <= 1'b0;
      end else begin
         if (cs_d_ff && !cs_s_ff)
            settle_ff <= sec_pkg::SETTLE_CYC;
         else if (settle_ff != 3'h0)
            settle_ff <= settle_ff - 3'h1;
         if (act)
            seen_ff <= tg_s_ff;
      end
   end

   // Self-timed cycle, unaffected by select
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_ff <= 1'b0;
         prog_ff <= '0;
         win_ff  <= '0;
         pend_ff <= '0;
      end else begin
         if (act && (wreq_ff.fill || wreq_ff.addr != sec_pkg::ADDR_SETUP)) begin
            busy_ff <= 1'b1;
            prog_ff <= PW'(PROG_CYCLES);
            win_ff  <= SW'(STAT_CYCLES);
            pend_ff <= wreq_ff;
         end else if (busy_ff) begin
            prog_ff <= prog_ff - PW'(1);
            if (win_ff != '0)
               win_ff <= win_ff - SW'(1);
            if (prog_end)
               busy_ff <= 1'b0;
         end
      end
   end

   // Array update at end of programming
   always_ff @(posedge clk) begin
      if (prog_end) begin
         if (pend_ff.fill) begin
            for (int i = 0; i < sec_pkg::NUM_WORDS; i++) begin
               mem[i] <= pend_ff.data;
            end
         end else begin
            mem[pend_ff.addr] <= pend_ff.data;
         end
      end
   end

   // Setup register: power-up copy and direct writes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         switch_config_reg <= sec_pkg::SETUP_RST;
         boot_ff           <= 1'b1;
      end else if (boot_ff) begin
         switch_config_reg <= mem[sec_pkg::ADDR_BOOT];
         boot_ff           <= 1'b0;
      end else if (act && !wreq_ff.fill && wreq_ff.addr == sec_pkg::ADDR_SETUP) begin
         switch_config_reg <= wreq_ff.data;
      end
   end

   // Status shown when select rises inside the window
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_on_ff  <= 1'b0;
         stat_val_ff <= 1'b0;
      end else begin
         stat_val_ff <= ~busy_ff;
         if (!cs_s_ff)
            stat_on_ff <= 1'b0;
         else if (!cs_d_ff && busy_ff && win_ff != '0)
            stat_on_ff <= 1'b1;
      end
   end

   // Pin is shared between data and status
   assign serial_out    = stat_on_ff ? stat_val_ff : do_bit_ff;
   assign serial_out_oe = (stat_on_ff & select_in) | do_oe_ff;

   // ==========================================================
   // Switch blocks, driven by the setup register and terminal levels
   // ==========================================================
   for (genvar g = 0; g < BLOCKS; g++) begin : g_blk
      logic [3:0] fld;                                   // This block's field
      assign fld = switch_config_reg[4*g +: 4];

      // Terminal drivers, select has no say
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            first_terminal_set_out[g]  <= 1'b0;
            first_terminal_set_oe[g]   <= 1'b0;
            second_terminal_set_out[g] <= 1'b0;
            second_terminal_set_oe[g]  <= 1'b0;
            analog_closed[g]           <= 1'b0;
         end else begin
            first_terminal_set_out[g]  <= 1'b0;
            first_terminal_set_oe[g]   <= 1'b0;
            second_terminal_set_out[g] <= 1'b0;
            second_terminal_set_oe[g]  <= 1'b0;
            analog_closed[g]           <= 1'b0;
            case (fld[3:2])
               // Both driven from b1 and lsb
               sec_pkg::FLD_LEVEL: begin
                  first_terminal_set_out[g]  <= fld[1];
                  first_terminal_set_oe[g]   <= 1'b1;
                  second_terminal_set_out[g] <= fld[0];
                  second_terminal_set_oe[g]  <= 1'b1;
               end
               // First driven, second tristate
               sec_pkg::FLD_A_SIDE: begin
                  first_terminal_set_oe[g] <= 1'b1;
                  case (fld[1:0])
                     2'h0:    first_terminal_set_out[g] <= 1'b0;
                     2'h1:    first_terminal_set_out[g] <= fb_s_ff[g];
                     2'h2:    first_terminal_set_out[g] <= ~fb_s_ff[g];
                     default: first_terminal_set_out[g] <= 1'b1;
                  endcase
               end
               // Second driven, first tristate
               sec_pkg::FLD_B_SIDE: begin
                  second_terminal_set_oe[g] <= 1'b1;
                  case (fld[1:0])
                     2'h0:    second_terminal_set_out[g] <= 1'b0;
                     2'h1:    second_terminal_set_out[g] <= fa_s_ff[g];
                     2'h2:    second_terminal_set_out[g] <= ~fa_s_ff[g];
                     default: second_terminal_set_out[g] <= 1'b1;
                  endcase
               end
               // Analog switch, b1 closes it
               default: begin
                  analog_closed[g] <= fld[1];
               end
            endcase
         end
      end

      // Live sample, closed switch reads zero
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sample_word_ff[8+g]  <= 1'b0;
            sample_word_ff[12+g] <= 1'b0;
         end else if (fld[3:2] == sec_pkg::FLD_ANALOG && fld[1]) begin
            sample_word_ff[8+g]  <= 1'b0;
            sample_word_ff[12+g] <= 1'b0;
         end else begin
            sample_word_ff[8+g]  <= fa_s_ff[g];
            sample_word_ff[12+g] <= fb_s_ff[g];
         end
      end
   end

   // Low byte of the sample is always zero
   assign sample_word_ff[7:0] = sec_pkg::SAMPLE_ZERO;

endmodule // sec_switch_eeprom

/* File: tb/sec_props.sv */
module sec_props #(parameter int BLOCKS = 4) (
   input wire logic              clk, rst, select_in, serial_out_oe,
   input wire logic [BLOCKS-1:0] first_terminal_set_oe, second_terminal_set_oe,
   input wire logic [BLOCKS-1:0] first_terminal_set_out, analog_closed);
   timeunit 1ns;
   timeprecision 1ps;
   // Terminal enables and first outputs, watched across select edges
   wire logic [3*BLOCKS-1:0] t = {first_terminal_set_oe, second_terminal_set_oe,
      first_terminal_set_out};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_oe_sel: assert property (!select_in |-> !serial_out_oe) else $error("oe unselected");
   a_oe_rise: assert property ($rose(serial_out_oe) |-> select_in) else $error("oe rose");
   a_oe_hold: assert property (serial_out_oe && select_in |=> serial_out_oe || !select_in)
      else $error("oe dropped");
   a_an_first: assert property ((analog_closed & first_terminal_set_oe) == '0)
      else $error("closed first driven");
   a_an_second: assert property ((analog_closed & second_terminal_set_oe) == '0)
      else $error("closed second driven");
   a_sel_rise: assert property ($rose(select_in) |=> $stable(t)) else $error("sel rise");
   a_sel_fall: assert property ($fell(select_in) |=> $stable(t)) else $error("sel fall");
   a_rst_idle: assert property ($fell(rst) |-> t == '0 && !serial_out_oe)
      else $error("not idle after reset");
   cover property ($rose(serial_out_oe));
   cover property ($rose(|analog_closed));
   cover property ($fell(select_in));
endmodule // sec_props
bind sec_switch_eeprom sec_props #(.BLOCKS(BLOCKS)) props_u (.clk(clk), .rst(rst),
   .select_in(select_in), .serial_out_oe(serial_out_oe),
   .first_terminal_set_oe(first_terminal_set_oe),
   .second_terminal_set_oe(second_terminal_set_oe),
   .first_terminal_set_out(first_terminal_set_out), .analog_closed(analog_closed));

/* File: tb/sec_host.sv */
module sec_host (output logic sclk, sel, sdi, input wire logic sdo);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin sclk = 0; sel = 0; sdi = 0; end
   // Idle clock, lead bit, opcode and address, then nd payload clocks
   task automatic xfer(input logic [7:0] ins, input logic [15:0] d, input int nd,
                       output logic [16:0] q);
      logic [25:0] v;
      v = {2'h1, ins, d};
      q = '0;
      sel = 1;
      for (int e = 0; e < 10 + nd; e++) begin
         sdi = e < 26 ? v[25-e] : 1'b0;
         #32 sclk = 1;
         #16 if (e > 8) q = {q[15:0], sdo};
         #16 sclk = 0;
      end
      sel = 0;
      sdi = ~sdi;
      #64;
   endtask
   // Raise select while programming, sample busy then ready
   task automatic stat(output logic [1:0] b);
      #250 sel = 1;
      #250 b[1] = sdo;
      #1500 b[0] = sdo;
      sel = 0;
      #64;
   endtask
endmodule // sec_host

/* File: tb/test_serial_eeprom_switch_config.sv */
module test_serial_eeprom_switch_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, sck, sel, sdi, sdo, sdoe;
   logic [3:0] ea = '0, eb = '0, fo, fe, so, se, ac, fi, si;
   logic [16:0] q;
   logic [1:0] b;
   logic [15:0] w;
   logic [31:0] e;
   int n_errors = 0, check_count = 0, seed = 66104;
   always #12.5 clk = ~clk;
   assign fi = fe & fo | ~fe & ea;
   assign si = se & so | ~se & eb;
   wire sdp = sdoe ? sdo : 1'b1; // Pull-up on the released data line
   sec_switch_eeprom #(.PROG_CYCLES(50), .STAT_CYCLES(20)) dut_u (.clk, .rst,
      .serial_clock_in(sck), .select_in(sel), .serial_in(sdi), .serial_out(sdo),
      .serial_out_oe(sdoe), .first_terminal_set_in(fi), .first_terminal_set_out(fo),
      .first_terminal_set_oe(fe), .second_terminal_set_in(si),
      .second_terminal_set_out(so), .second_terminal_set_oe(se), .analog_closed(ac));
   sec_host host_u (.sclk(sck), .sel, .sdi, .sdo(sdp));
   // Expected sample word above, masked drive state below
   function automatic logic [31:0] drv(input logic [15:0] c, input logic [3:0] a, b);
      logic [3:0] m, f_o, f_e, s_o, s_e, k;
      for (int i = 0; i < 4; i++) begin
         m = c[4*i+:4];
         f_e[i] = ~m[3];
         s_e[i] = ~m[2];
         k[i] = &m[3:1];
         f_o[i] = m == 5 ? b[i] : m == 6 ? ~b[i] : m[2] ? m[0] : m[1];
         s_o[i] = m == 9 ? a[i] : m == 10 ? ~a[i] : m[0];
      end
      return {~k & (s_e & s_o | ~s_e & b), ~k & (f_e & f_o | ~f_e & a), 8'h00,
         f_o & f_e, f_e, s_o & s_e, s_e};
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic op(input logic [7:0] i, input logic [15:0] d, input int nd);
      host_u.xfer(i, d, nd, q);
      repeat (80) @(posedge clk);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      op({sec_pkg::OP_EXT, sec_pkg::EXT_UNLOCK, 4'h0}, '0, 0);
      op({sec_pkg::OP_WRITE, sec_pkg::ADDR_BOOT}, 16'h2170, 16);
      rst <= 1;
      repeat (4) @(posedge clk);
      rst <= 0;
      repeat (4) @(posedge clk);
      e = drv(16'h2170, ea, eb);
      chk("boot", {fo & fe, fe, so & se, se}, e[15:0]);
      $display("boot test done");
      op({sec_pkg::OP_EXT, sec_pkg::EXT_UNLOCK, 4'h0}, '0, 0);
      for (int n = 0; n < 6; n++) begin
         w = 16'($random(seed));
         ea <= 4'($random(seed));
         eb <= 4'($random(seed));
         op({sec_pkg::OP_WRITE, sec_pkg::ADDR_SETUP}, w, 16);
         e = drv(w, ea, eb);
         chk("drive", {fo & fe, fe, so & se, se}, e[15:0]);
         chk("closed", ac, {&w[15:13], &w[11:9], &w[7:5], &w[3:1]});
         op({sec_pkg::OP_READ, sec_pkg::ADDR_SAMPLE}, '0, 16);
         chk("sample", q, {1'b0, e[31:16]});
         op({sec_pkg::OP_READ, sec_pkg::ADDR_SETUP}, '0, 16);
         chk("setup", q, {1'b0, w});
      end
      $display("random test done");
      op({sec_pkg::OP_WRITE, sec_pkg::ADDR_SAMPLE}, 16'hffff, 16);
      host_u.xfer({sec_pkg::OP_EXT, sec_pkg::EXT_FILL, 4'h0}, 16'h5a3c, 16, q);
      host_u.stat(b);
      chk("status", b, 2'b01);
      repeat (80) @(posedge clk);
      op({sec_pkg::OP_EXT, sec_pkg::EXT_LOCK, 4'h0}, '0, 0);
      op({sec_pkg::OP_WRITE, 6'h00}, 16'h1234, 16);
      op({sec_pkg::OP_READ, 6'h00}, '0, 16);
      chk("fill0", q, {1'b0, 16'h5a3c});
      op({sec_pkg::OP_READ, sec_pkg::ADDR_SAMPLE}, '0, 32);
      chk("wrap", q, {1'b0, 16'h5a3c});
      op({sec_pkg::OP_READ, sec_pkg::ADDR_BOOT}, '0, 16);
      chk("fill61", q, {1'b0, 16'h5a3c});
      op({sec_pkg::OP_READ, sec_pkg::ADDR_SETUP}, '0, 16);
      chk("fillsetup", q, {1'b0, w});
      $display("lock test done");
      test_done;
   end
   initial begin
      #1ms;
      n_errors++;
      test_done;
   end
endmodule // test_serial_eeprom_switch_config
